// File: logic/vc3_pkg.sv
// Summary of operation
// - Management request connects one input to one output
// - Management request tears down an established connection
// - Connection keeps type, direction and point identifiers
// - Broadcast is several connections sharing one input
// - Configuration changes leave passing traffic undisturbed
// - Unconnected output carries unequipped VC-3, fail false
// - Sink selector picks working or protection input
// - Source bridge feeds both outputs from normal input
// - 1+1 unidirectional, fail and degrade high priority
// - Revertive return waits programmable wait-to-restore time
// - Hold-off persistence before switching; switch within 50 ms
// - Fail/degrade sources chosen by monitoring kind
// - External commands accepted per operation type
// - Protection type selects indications feeding the selector
// - Source fills three overhead bytes, passes the rest
// - Trace identifier placed in J1 one byte per frame, repeated every 16 frames
// - B3 holds even BIP-8 of previous frame
// - Error count coded binary in G1 bits 1-4
// - G1 bit 5 follows remote defect within 250 us
// - G1 bits 6-8 carry no meaning
package vc3_pkg;
    localparam int CLK_MHZ = 250;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
    localparam int SEC_MS = 1000;
    localparam int HOLDOFF_STEP_MS = 100;
    localparam int HOLDOFF_MAX_STEPS = 100;
    localparam int SWITCH_TIME_MS = 50;
    localparam int RDI_LATENCY_US = 250;
    localparam int WTR_MIN_S = 300;
    localparam int WTR_MAX_S = 720;
    localparam int FRAME_BYTES = 765;
    localparam int POH_STRIDE = 85;
    localparam logic [9:0] J1_POS = 10'h000;
    localparam logic [9:0] B3_POS = 10'h055;
    localparam logic [9:0] G1_POS = 10'h0FF;
    localparam logic [9:0] LAST_POS = 10'h2FC;
    localparam int TRACE_BYTES = 16;
    localparam logic [7:0] UNEQ_BYTE = 8'h00;
    localparam logic [2:0] G1_SPARE = 3'h0;
    localparam logic [3:0] REI_MAX = 4'h8;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        unprotected,
        inherent_monitored_protection,
        nonintrusive_monitored_protection,
        sublayer_monitored_protection
    } conn_type_t;

    typedef enum logic [2:0] {
        no_cmd,
        clear_cmd,
        lockout_cmd,
        forced_switch_cmd,
        forced_switch_work_cmd,
        manual_switch_cmd,
        manual_switch_work_cmd
    } ext_cmd_t;

    typedef enum logic [1:0] {
        sel_working,
        sel_protection,
        sel_wtr
    } sel_state_t;
endpackage

// File: logic/vc3_path_connect_and_trail_source.sv
`timescale 1ns/1ps
module vc3_byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic mclk, // Core clock
    input wire logic arst_n, // Async reset
    input wire logic ce, // Clock enable
    input wire logic in_valid, // Write request
    output logic in_ready, // Room available
    input wire logic [WIDTH-1:0] in_data, // Write word
    output logic out_valid, // Word available
    input wire logic out_ready, // Drain accepts
    output logic [WIDTH-1:0] out_data // Head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    assign in_ready = count_ff != (AW+1)'(DEPTH);
    assign out_valid = count_ff != '0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_ff];

    always_ff @(posedge mclk) begin
        if (ce && push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else if (ce) begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

module vc3_path_connect_and_trail_source #(
    parameter int N_IN = 4,
    parameter int N_OUT = 4,
    parameter int TICK_CYCLES = vc3_pkg::TICK_CYCLES,
    parameter int FIFO_DEPTH = vc3_pkg::FIFO_DEPTH
) (
    input wire logic mclk, // Core clock
    input wire logic arst_n, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic [N_IN-1:0] in_ck, // Input byte clocks
    input wire logic [N_IN-1:0] in_fs, // Input frame starts
    input wire logic [N_IN-1:0][7:0] in_data, // Input bytes
    input wire logic [N_IN-1:0] in_ssf, // Server signal fail per input
    input wire logic [N_IN-1:0] in_tsf, // Trail signal fail per input
    input wire logic [N_IN-1:0] in_tsd, // Trail signal degrade per input
    input wire logic ti_ck, // Timing clock
    input wire logic ti_fs, // Timing frame start
    input wire logic conn_req, // Connection request pulse
    input wire logic conn_connect, // 1 establish, 0 tear down
    input wire logic [$clog2(N_OUT)-1:0] conn_out, // Output point
    input wire logic [$clog2(N_IN)-1:0] conn_in, // Working input point
    input wire logic [$clog2(N_IN)-1:0] conn_prot_in, // Protection input point
    input wire vc3_pkg::conn_type_t conn_type, // Connection type
    input wire logic conn_bidir, // Bidirectional attribute
    input wire logic conn_bridge_en, // Also bridge a second output
    input wire logic [$clog2(N_OUT)-1:0] conn_bridge_out, // Bridged output point
    input wire logic operation_type, // 1 revertive
    input wire logic [9:0] wait_to_restore_time, // Seconds
    input wire logic [6:0] holdoff_time, // Steps of 100 ms
    input wire logic external_command_valid, // Command pulse
    input wire vc3_pkg::ext_cmd_t external_command, // Command code
    output vc3_pkg::ext_cmd_t active_command, // Command in force
    output logic [N_OUT-1:0][7:0] out_data, // Output bytes
    output logic [N_OUT-1:0] out_strobe, // Output byte pulse
    output logic [N_OUT-1:0] out_fs, // Output frame start
    output logic [N_OUT-1:0] out_ssf, // Output server signal fail
    output logic [N_OUT-1:0] out_connected, // Output has a connection
    output logic [N_OUT-1:0] out_bidir, // Stored direction attribute
    output logic [N_OUT-1:0] out_sel_prot, // Selector on protection
    input wire logic tt_ai_ck, // Adapted byte clock
    input wire logic tt_ai_fs, // Adapted frame start
    input wire logic [7:0] tt_ai_data, // Adapted bytes
    input wire logic [3:0] remote_error_count_in, // Remote error count
    input wire logic remote_defect_in, // Remote defect
    input wire logic [127:0] transmitted_trace_id, // Trace message
    output logic tt_ai_ready, // Buffer has room
    output logic [7:0] tt_ci_data, // Built frame byte
    output logic tt_ci_fs, // Built frame start
    output logic tt_ci_valid, // Byte available
    input wire logic tt_ci_ready // Drain accepts
);
    localparam int IW = $clog2(N_IN);
    localparam int OW = $clog2(N_OUT);
    localparam int TW = $clog2(TICK_CYCLES);

    // Two-stage synchronisers; third stage only for edge detection
    logic [N_IN-1:0] ck_s1_ff, ck_s2_ff, ck_s3_ff, fs_s1_ff, fs_s2_ff;
    logic [N_IN-1:0] ssf_s1_ff, ssf_s2_ff, tsf_s1_ff, tsf_s2_ff, tsd_s1_ff, tsd_s2_ff;
    logic [N_IN-1:0][7:0] d_s1_ff, d_s2_ff;
    logic [2:0] ti_ck_ff;
    logic [1:0] ti_fs_ff;
    logic [N_IN-1:0] in_edge;
    logic ti_edge;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ck_s1_ff <= '0;
            ck_s2_ff <= '0;
            ck_s3_ff <= '0;
            fs_s1_ff <= '0;
            fs_s2_ff <= '0;
            ssf_s1_ff <= '0;
            ssf_s2_ff <= '0;
            tsf_s1_ff <= '0;
            tsf_s2_ff <= '0;
            tsd_s1_ff <= '0;
            tsd_s2_ff <= '0;
            d_s1_ff <= '0;
            d_s2_ff <= '0;
            ti_ck_ff <= '0;
            ti_fs_ff <= '0;
        end else if (ce) begin
            ck_s1_ff <= in_ck;
            ck_s2_ff <= ck_s1_ff;
            ck_s3_ff <= ck_s2_ff;
            fs_s1_ff <= in_fs;
            fs_s2_ff <= fs_s1_ff;
            ssf_s1_ff <= in_ssf;
            ssf_s2_ff <= ssf_s1_ff;
            tsf_s1_ff <= in_tsf;
            tsf_s2_ff <= tsf_s1_ff;
            tsd_s1_ff <= in_tsd;
            tsd_s2_ff <= tsd_s1_ff;
            d_s1_ff <= in_data;
            d_s2_ff <= d_s1_ff;
            ti_ck_ff <= {ti_ck_ff[1:0], ti_ck};
            ti_fs_ff <= {ti_fs_ff[0], ti_fs};
        end
    end

    assign in_edge = ck_s2_ff & ~ck_s3_ff;
    assign ti_edge = ti_ck_ff[1] & ~ti_ck_ff[2];

    // Millisecond and second ticks shared by hold-off and restore timers
    logic [TW-1:0] tick_cnt_ff;
    logic [9:0] ms_cnt_ff;
    logic ms_tick;
    logic sec_tick;

    assign ms_tick = tick_cnt_ff == TW'(TICK_CYCLES - 1);
    assign sec_tick = ms_tick && (ms_cnt_ff == 10'(vc3_pkg::SEC_MS - 1));

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_ff <= '0;
            ms_cnt_ff <= '0;
        end else if (ce) begin
            tick_cnt_ff <= ms_tick ? '0 : tick_cnt_ff + 1'b1;
            if (ms_tick) begin
                ms_cnt_ff <= sec_tick ? '0 : ms_cnt_ff + 1'b1;
            end
        end
    end

    function automatic logic cmd_allowed(input vc3_pkg::ext_cmd_t cmd, input logic revertive);
        case (cmd)
            vc3_pkg::forced_switch_work_cmd, vc3_pkg::manual_switch_work_cmd: cmd_allowed = !revertive;
            vc3_pkg::no_cmd: cmd_allowed = 1'b0;
            default: cmd_allowed = 1'b1;
        endcase
    endfunction

    // Returns {fail, degrade} for one input under the protection kind
    function automatic logic [1:0] cond_of(input vc3_pkg::conn_type_t kind, input logic ssf,
                                           input logic tsf, input logic tsd);
        if (kind == vc3_pkg::inherent_monitored_protection) begin
            cond_of = {ssf, 1'b0};
        end else begin
            cond_of = {tsf, tsd};
        end
    endfunction

    vc3_pkg::ext_cmd_t cmd_ff;
    assign active_command = cmd_ff;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_ff <= vc3_pkg::no_cmd;
        end else if (ce && external_command_valid && cmd_allowed(external_command, operation_type)) begin
            cmd_ff <= (external_command == vc3_pkg::clear_cmd) ? vc3_pkg::no_cmd : external_command;
        end
    end

    // Connection table, one entry per output
    logic [N_OUT-1:0] conn_ff;
    logic [N_OUT-1:0][IW-1:0] work_ff, prot_ff;
    vc3_pkg::conn_type_t type_ff [N_OUT];
    logic [N_OUT-1:0] bidir_ff;
    logic [13:0] ho_limit;

    assign ho_limit = 14'(holdoff_time) * 14'(vc3_pkg::HOLDOFF_STEP_MS);
    assign out_connected = conn_ff;
    assign out_bidir = bidir_ff;

    genvar j;
    generate
        for (j = 0; j < N_OUT; j++) begin : g_out
            logic hit;
            logic bridge_hit;
            logic [1:0] w_cond, p_cond;
            logic w_bad, p_bad, w_f, p_f, prot_active;
            logic [13:0] w_ho_ff, p_ho_ff;
            logic [9:0] wtr_cnt_ff;
            logic [IW-1:0] src;
            vc3_pkg::sel_state_t state_ff, nxt_state;

            assign hit = conn_req && (conn_out == OW'(j));
            assign bridge_hit = conn_req && conn_connect && conn_bridge_en && (conn_bridge_out == OW'(j));

            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    conn_ff[j] <= 1'b0;
                    work_ff[j] <= '0;
                    prot_ff[j] <= '0;
                    type_ff[j] <= vc3_pkg::unprotected;
                    bidir_ff[j] <= 1'b0;
                end else if (ce) begin
                    if (hit && conn_connect) begin
                        conn_ff[j] <= 1'b1;
                        work_ff[j] <= conn_in;
                        prot_ff[j] <= conn_prot_in;
                        type_ff[j] <= conn_type;
                        bidir_ff[j] <= conn_bidir;
                    end else if (hit) begin
                        conn_ff[j] <= 1'b0;
                    end else if (bridge_hit) begin
                        conn_ff[j] <= 1'b1;
                        work_ff[j] <= conn_in;
                        type_ff[j] <= vc3_pkg::unprotected;
                        bidir_ff[j] <= conn_bidir;
                    end
                end
            end

            assign w_cond = cond_of(type_ff[j], ssf_s2_ff[work_ff[j]], tsf_s2_ff[work_ff[j]],
                                    tsd_s2_ff[work_ff[j]]);
            assign p_cond = cond_of(type_ff[j], ssf_s2_ff[prot_ff[j]], tsf_s2_ff[prot_ff[j]],
                                    tsd_s2_ff[prot_ff[j]]);
            // Fail and degrade share one priority level
            assign w_bad = |w_cond;
            assign p_bad = |p_cond;

            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    w_ho_ff <= '0;
                    p_ho_ff <= '0;
                end else if (ce) begin
                    if (!w_bad) begin
                        w_ho_ff <= '0;
                    end else if (ms_tick && w_ho_ff < ho_limit) begin
                        w_ho_ff <= w_ho_ff + 1'b1;
                    end
                    if (!p_bad) begin
                        p_ho_ff <= '0;
                    end else if (ms_tick && p_ho_ff < ho_limit) begin
                        p_ho_ff <= p_ho_ff + 1'b1;
                    end
                end
            end

            assign w_f = w_bad && (w_ho_ff >= ho_limit);
            assign p_f = p_bad && (p_ho_ff >= ho_limit);
            assign prot_active = conn_ff[j] && (type_ff[j] != vc3_pkg::unprotected);

            always_comb begin
                nxt_state = state_ff;
                if (!prot_active) begin
                    nxt_state = vc3_pkg::sel_working;
                end else begin
                    case (cmd_ff)
                        vc3_pkg::lockout_cmd: nxt_state = vc3_pkg::sel_working;
                        vc3_pkg::forced_switch_cmd: begin
                            nxt_state = p_f ? vc3_pkg::sel_working : vc3_pkg::sel_protection;
                        end
                        vc3_pkg::forced_switch_work_cmd: nxt_state = vc3_pkg::sel_working;
                        default: begin
                            if (w_f && !p_f) begin
                                nxt_state = vc3_pkg::sel_protection;
                            end else if (p_f && !w_f) begin
                                nxt_state = vc3_pkg::sel_working;
                            end else if (w_f) begin
                                nxt_state = (state_ff == vc3_pkg::sel_working) ? state_ff
                                                                              : vc3_pkg::sel_protection;
                            end else if (cmd_ff == vc3_pkg::manual_switch_cmd) begin
                                nxt_state = vc3_pkg::sel_protection;
                            end else if (cmd_ff == vc3_pkg::manual_switch_work_cmd) begin
                                nxt_state = vc3_pkg::sel_working;
                            end else if (!operation_type) begin
                                nxt_state = (state_ff == vc3_pkg::sel_working) ? state_ff
                                                                              : vc3_pkg::sel_protection;
                            end else if (state_ff == vc3_pkg::sel_protection) begin
                                nxt_state = vc3_pkg::sel_wtr;
                            end else if (state_ff == vc3_pkg::sel_wtr && wtr_cnt_ff >= wait_to_restore_time) begin
                                nxt_state = vc3_pkg::sel_working;
                            end
                        end
                    endcase
                end
            end

            // Decision lands within one core cycle, far inside the switch time
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    state_ff <= vc3_pkg::sel_working;
                    wtr_cnt_ff <= '0;
                end else if (ce) begin
                    state_ff <= nxt_state;
                    if (state_ff != vc3_pkg::sel_wtr) begin
                        wtr_cnt_ff <= '0;
                    end else if (sec_tick && wtr_cnt_ff != 10'h3FF) begin
                        wtr_cnt_ff <= wtr_cnt_ff + 1'b1;
                    end
                end
            end

            // The selector state picks the source leg; connect and bridge edits rewrite the working leg
            assign src = (state_ff != vc3_pkg::sel_working) ? prot_ff[j] : work_ff[j];
            assign out_sel_prot[j] = state_ff != vc3_pkg::sel_working;

            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    out_data[j] <= '0;
                    out_strobe[j] <= 1'b0;
                    out_fs[j] <= 1'b0;
                    out_ssf[j] <= 1'b0;
                end else if (ce) begin
                    if (conn_ff[j]) begin
                        out_data[j] <= d_s2_ff[src];
                        out_strobe[j] <= in_edge[src];
                        out_fs[j] <= fs_s2_ff[src];
                        out_ssf[j] <= ssf_s2_ff[src];
                    end else begin
                        out_data[j] <= vc3_pkg::UNEQ_BYTE;
                        out_strobe[j] <= ti_edge;
                        out_fs[j] <= ti_fs_ff[1];
                        out_ssf[j] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Trail termination source
    logic [2:0] tt_ck_ff;
    logic [1:0] tt_fs_ff;
    logic [7:0] tt_d1_ff, tt_d2_ff;
    logic tt_edge;
    logic [9:0] pos_ff, cur_pos;
    logic [3:0] trace_idx_ff;
    logic [7:0] bip_ff, b3_ff, tt_byte;
    logic fifo_in_ready;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tt_ck_ff <= '0;
            tt_fs_ff <= '0;
            tt_d1_ff <= '0;
            tt_d2_ff <= '0;
        end else if (ce) begin
            tt_ck_ff <= {tt_ck_ff[1:0], tt_ai_ck};
            tt_fs_ff <= {tt_fs_ff[0], tt_ai_fs};
            tt_d1_ff <= tt_ai_data;
            tt_d2_ff <= tt_d1_ff;
        end
    end

    assign tt_edge = tt_ck_ff[1] & ~tt_ck_ff[2];
    assign cur_pos = tt_fs_ff[1] ? vc3_pkg::J1_POS
                   : (pos_ff == vc3_pkg::LAST_POS) ? vc3_pkg::J1_POS : pos_ff + 1'b1;

    always_comb begin
        case (cur_pos)
            vc3_pkg::J1_POS: tt_byte = transmitted_trace_id[(4'hF - trace_idx_ff) * 8 +: 8];
            vc3_pkg::B3_POS: tt_byte = b3_ff;
            vc3_pkg::G1_POS: tt_byte = {remote_error_count_in, remote_defect_in, vc3_pkg::G1_SPARE};
            default: tt_byte = tt_d2_ff;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pos_ff <= vc3_pkg::LAST_POS;
            trace_idx_ff <= '0;
            bip_ff <= '0;
            b3_ff <= '0;
        end else if (ce && tt_edge) begin
            pos_ff <= cur_pos;
            if (cur_pos == vc3_pkg::J1_POS) begin
                trace_idx_ff <= trace_idx_ff + 1'b1;
                b3_ff <= bip_ff;
                bip_ff <= tt_byte;
            end else begin
                bip_ff <= bip_ff ^ tt_byte;
            end
        end
    end

    assign tt_ai_ready = fifo_in_ready;

    vc3_byte_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .ce(ce),
        .in_valid(tt_edge),
        .in_ready(fifo_in_ready),
        .in_data({cur_pos == vc3_pkg::J1_POS, tt_byte}),
        .out_valid(tt_ci_valid),
        .out_ready(tt_ci_ready),
        .out_data({tt_ci_fs, tt_ci_data})
    );
endmodule

// File: test/vc3_sva.sv
`timescale 1ns/1ps
module vc3_sva #(
    parameter int N_OUT = 4
) (
    input wire logic mclk, // Clock
    input wire logic arst_n, // Reset
    input wire logic ce, // Enable
    input wire logic conn_req, // Edit
    input wire logic conn_connect, // Establish
    input wire logic [$clog2(N_OUT)-1:0] conn_out, // Output
    input wire logic conn_bidir, // Direction
    input wire logic operation_type, // Revertive
    input wire logic external_command_valid, // Pulse
    input wire vc3_pkg::ext_cmd_t external_command, // Code
    input wire vc3_pkg::ext_cmd_t active_command, // In force
    input wire logic [N_OUT-1:0][7:0] out_data, // Bytes
    input wire logic [N_OUT-1:0] out_ssf, // Fail
    input wire logic [N_OUT-1:0] out_connected, // Linked
    input wire logic [N_OUT-1:0] out_bidir, // Direction
    input wire logic [N_OUT-1:0] out_sel_prot // Protection
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_edit;
        ce && conn_req;
    endsequence
    sequence s_cmd;
        ce && external_command_valid;
    endsequence
    a_conn_made: assert property (s_edit ##0 conn_connect
        |=> out_connected[$past(conn_out)]) else $error("link missing");
    a_conn_gone: assert property (s_edit ##0 !conn_connect
        |=> !out_connected[$past(conn_out)]) else $error("link kept");
    a_dir_kept: assert property (s_edit ##0 conn_connect
        |=> out_bidir[$past(conn_out)] == $past(conn_bidir)) else $error("direction lost");
    a_uneq_idle: assert property ((!out_connected[0]) [*3]
        |-> !out_ssf[0] && out_data[0] == 8'h00) else $error("idle output not blank");
    a_work_refused: assert property (s_cmd ##0 operation_type && external_command inside
        {vc3_pkg::forced_switch_work_cmd, vc3_pkg::manual_switch_work_cmd} |=> $stable(active_command))
        else $error("command not refused");
    a_cmd_taken: assert property (s_cmd ##0 !operation_type && external_command > vc3_pkg::clear_cmd
        |=> active_command == $past(external_command)) else $error("command not taken");
    a_clear_cmd: assert property (s_cmd ##0 external_command == vc3_pkg::clear_cmd
        |=> active_command == vc3_pkg::no_cmd) else $error("clear ignored");
    a_lock_working: assert property ((active_command == vc3_pkg::lockout_cmd) [*3]
        |-> !(|out_sel_prot)) else $error("lockout ignored");
endmodule

bind vc3_path_connect_and_trail_source vc3_sva #(.N_OUT(N_OUT)) i_vc3_sva (.*);

// File: test/vc3_adapt_model.sv
`timescale 1ns/1ps
module vc3_adapt_model (
    output logic ck, // Byte clock
    output logic fs, // Frame start
    output logic [7:0] data // Byte
);
    int pos = 0;
    // Off-grid start keeps link edges clear of core clock edges
    initial begin
        ck = 1'h0;
        #1.3;
        forever #40 ck = ~ck;
    end
    always @(negedge ck) pos <= (pos + 1) % vc3_pkg::FRAME_BYTES;
    assign fs = pos == 0;
    assign data = pos[7:0] ^ 8'hA5;
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
    logic mclk = 1'h0, arst_n = 1'h0, ce = 1'h1, pck, pfs, conn_req = 1'h0, conn_connect, conn_bidir;
    logic conn_bridge_en, operation_type = 1'h0, remote_defect_in = 1'h1, external_command_valid = 1'h0;
    logic ti_ck, ti_fs, tt_ai_ck, tt_ai_fs, tt_ai_ready, tt_ci_fs, tt_ci_valid, tt_ci_ready = 1'h1;
    logic [1:0] conn_out, conn_in, conn_prot_in, conn_bridge_out = 2'h1;
    logic [3:0] in_ssf = 4'h0, in_tsf = 4'h0, in_tsd = 4'h0, in_ck, in_fs, out_strobe, out_fs, out_ssf;
    logic [3:0] out_connected, out_bidir, out_sel_prot, remote_error_count_in = 4'h8;
    logic [3:0][7:0] in_data, out_data;
    logic [7:0] pd, tt_ai_data, tt_ci_data, par, pb, b3, g1, j1;
    logic [9:0] wait_to_restore_time = 10'h001;
    logic [6:0] holdoff_time = 7'h01;
    logic [127:0] transmitted_trace_id = {8{16'h3C5A}};
    vc3_pkg::conn_type_t conn_type;
    vc3_pkg::ext_cmd_t external_command = vc3_pkg::no_cmd, active_command;
    int fail_count = 0, num_checks = 0, cyc = 0, pos = 0, fr = 0;
    assign {ti_ck, ti_fs, tt_ai_ck, tt_ai_fs, tt_ai_data} = {pck, pfs, pck, pfs, pd};
    assign {in_ck, in_fs} = {{4{pck}}, {4{pfs}}};
    assign in_data = {pd ^ 8'h03, pd ^ 8'h02, pd ^ 8'h01, pd};
    vc3_adapt_model i_vc3_adapt_model (.ck(pck), .fs(pfs), .data(pd));
    // Short tick: one ms is ten core cycles
    vc3_path_connect_and_trail_source #(.TICK_CYCLES(10)) i_vc3_path_connect_and_trail_source (.*);
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 80000) begin
            fail_count++;
            print_verdict();
        end
    end
    always @(posedge mclk) if (tt_ci_valid && tt_ci_ready) begin
        pos = tt_ci_fs ? 0 : pos + 1;
        fr += int'(tt_ci_fs);
        pb = tt_ci_fs ? par : pb;
        par = (tt_ci_fs ? 8'h00 : par) ^ tt_ci_data;
        case (pos)
            0: j1 = tt_ci_data;
            10: chk(tt_ci_data, 8'hAF);
            85: b3 = tt_ci_data;
            255: g1 = tt_ci_data;
        endcase
    end
    task automatic print_verdict();
        if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic req(input logic c, input logic [1:0] o, i, p, input vc3_pkg::conn_type_t t, input logic b);
        @(posedge mclk);
        {conn_req, conn_connect, conn_bidir, conn_out, conn_in, conn_prot_in, conn_bridge_en} <= {1'h1, c, b, o, i, p, b};
        conn_type <= t;
        @(posedge mclk);
        conn_req <= 1'h0;
    endtask
    task automatic cmd(input vc3_pkg::ext_cmd_t c, input vc3_pkg::ext_cmd_t e);
        @(posedge mclk);
        {external_command, external_command_valid} <= {c, 1'h1};
        @(posedge mclk);
        external_command_valid <= 1'h0;
        @(negedge mclk);
        chk(8'(active_command), 8'(e));
    endtask
    task automatic stb(input int k);
        for (int n = 0; n < 100 && (n < 2 || out_strobe[k] !== 1'h1); n++)
            @(negedge mclk);
    endtask
    task automatic t_route();
        req(1'h1, 2'h0, 2'h2, 2'h0, vc3_pkg::unprotected, 1'h1);
        in_ssf <= 4'h4;
        stb(0);
        chk(out_data[0], pd ^ 8'h02);
        chk(out_data[1], pd ^ 8'h02);
        req(1'h0, 2'h0, 2'h2, 2'h0, vc3_pkg::unprotected, 1'h0);
        repeat (8) @(negedge mclk);
        stb(0);
        chk({3'h0, out_fs[0], out_ssf[1:0], out_connected[1:0]}, {3'h0, pfs, 4'hA});
        chk(out_data[0], 8'h00);
    endtask
    task automatic t_select();
        req(1'h1, 2'h2, 2'h0, 2'h1, vc3_pkg::inherent_monitored_protection, 1'h0);
        in_ssf <= 4'h1;
        repeat (500) @(negedge mclk);
        chk({7'h00, out_sel_prot[2]}, 8'h00);
        for (int n = 0; n < 1000 && out_sel_prot[2] !== 1'h1; n++)
            @(negedge mclk);
        chk({7'h00, out_sel_prot[2]}, 8'h01);
        stb(2);
        chk(out_data[2], pd ^ 8'h01);
        cmd(vc3_pkg::lockout_cmd, vc3_pkg::lockout_cmd);
        repeat (3) @(negedge mclk);
        chk({4'h0, out_sel_prot}, 8'h00);
    endtask
    task automatic t_cmds();
        cmd(vc3_pkg::clear_cmd, vc3_pkg::no_cmd);
        for (int k = 3; k < 7; k++)
            cmd(vc3_pkg::ext_cmd_t'(k), vc3_pkg::ext_cmd_t'(k));
        cmd(vc3_pkg::no_cmd, vc3_pkg::manual_switch_work_cmd);
        @(posedge mclk) operation_type <= 1'h1;
        cmd(vc3_pkg::clear_cmd, vc3_pkg::no_cmd);
        cmd(vc3_pkg::forced_switch_work_cmd, vc3_pkg::no_cmd);
        cmd(vc3_pkg::manual_switch_cmd, vc3_pkg::manual_switch_cmd);
    endtask
    task automatic t_trail();
        wait (fr >= 2 && pos > 255);
        chk(j1, 8'h5A);
        chk(b3, pb);
        chk(g1, 8'h88);
        @(posedge mclk);
        {remote_error_count_in, remote_defect_in} <= 5'h0A;
        wait (fr >= 3 && pos > 255);
        chk(g1, 8'h50);
        @(posedge mclk);
        tt_ci_ready <= 1'h0;
        for (int n = 0; n < 400 && tt_ai_ready !== 1'h0; n++)
            @(negedge mclk);
        chk({6'h00, tt_ai_ready, tt_ci_valid}, 8'h01);
        @(posedge mclk);
        tt_ci_ready <= 1'h1;
        for (int n = 0; n < 40 && tt_ci_valid !== 1'h0; n++)
            @(negedge mclk);
        chk({6'h00, tt_ai_ready, tt_ci_valid}, 8'h02);
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        arst_n <= 1'h1;
        t_route();
        t_select();
        t_cmds();
        t_trail();
        print_verdict();
    end
endmodule
